// [jog_remote_regs.vh]
// Register offsets, field codes, reset values and timing figures for the jog and remote-speed logic.
// Operation
// - Hold jog frequency, default 5 Hz, 0 to 400 Hz; run at it in jog.
// - Hold jog ramp time, default 0.5 s, 0 to 3600 s, measured to 60 Hz.
// - Jog uses one ramp time for both acceleration and deceleration.
// - With jog selected, forward and reverse start inputs start and stop the motor.
// - A terminal whose function code is 5 carries the jog select function.
// - Outside mode 4, panel jog runs only while the panel start button is held.
// - Ramp pattern 1 measures the jog ramp time to base frequency.
// - Jog ignores second-function input for ramp times, other uses unaffected.
// - Mode 4: run or forward/reverse keys start jog, stop key stops it.
// - Jog is disabled entirely in operation mode 3.
// - Remote selection 0 multi-speed, 1 stored, 2 unstored, 3 unstored cleared at stop.
// - Remote selection 1 to 3 turns speed inputs into accelerate, decelerate, clear.
// - Remote offset adds to a base command chosen by operation mode.
// - Selection 1 saves the remote frequency and resumes from it after power cycle.
// - Save at start release, and minutely compare-and-write while accel/decel are off.
// - Offset limited zero to maximum frequency; total capped at main plus maximum.
// - Remote ramps use second times, or longer primary times while second-function off.
// - Selections 1 and 2 change the offset even with both starts inactive.
// - Remote setting also works in network operation mode.
// - Remote setting is disabled during jog or PID control.
// - External source priority: jog, multi-speed, analog input 4, analog input 2.
`ifndef JOG_REMOTE_REGS_VH
`define JOG_REMOTE_REGS_VH
`define ADDR_JOG_FREQ 8'h00
`define ADDR_JOG_RAMP 8'h04
`define ADDR_REF_FREQ 8'h08
`define ADDR_BASE_FREQ 8'h0C
`define ADDR_RAMP_PATTERN 8'h10
`define ADDR_OP_MODE 8'h14
`define ADDR_REMOTE_SEL 8'h18
`define ADDR_TERM_ASSIGN 8'h1C
`define ADDR_MAX_FREQ 8'h20
`define ADDR_ACCEL_TIME 8'h24
`define ADDR_DECEL_TIME 8'h28
`define ADDR_SECOND_ACCEL 8'h2C
`define ADDR_SECOND_DECEL 8'h30
`define ADDR_START_FREQ 8'h34
`define ADDR_STATUS 8'h38
`define ADDR_OUT_FREQ 8'h3C
`define ADDR_REMOTE_OFFSET 8'h40
`define ADDR_STORED_FREQ 8'h44
`define RST_JOG_FREQ 16'h01F4
`define MAX_SET_FREQ 16'h9C40
`define RST_JOG_RAMP 16'h0005
`define MAX_SET_TIME 16'h8CA0
`define RST_REF_FREQ 16'h1770
`define RST_BASE_FREQ 16'h1770
`define RST_MAX_FREQ 16'h2EE0
`define RST_ACCEL_TIME 16'h0032
`define RST_START_FREQ 16'h0032
`define TIME_NOT_SET 16'h270F
`define RST_TERM_ASSIGN 20'h53210
`define FUNC_LOW 4'h0
`define FUNC_MID 4'h1
`define FUNC_HIGH 4'h2
`define FUNC_SECOND 4'h3
`define FUNC_JOG 4'h5
`define MODE_SWITCH 3'h0
`define MODE_PANEL 3'h1
`define MODE_COMBINED_FREQ 3'h3
`define MODE_COMBINED_START 3'h4
`define REMOTE_MULTI 2'h0
`define REMOTE_STORED 2'h1
`define REMOTE_CLEAR_AT_STOP 2'h3
`define PATTERN_S_A 2'h1
`define CYC_PER_TIME_UNIT 32'd20000000
`define SAVE_PERIOD_CYC 40'd12000000000
`endif

// [jog_remote_speed.v]
// Jog and remote up/down speed-setting frequency command logic with ramp generator.
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`include "jog_remote_regs.vh"
module jog_remote_speed #(
   parameter [31:0] CYC_PER_UNIT = `CYC_PER_TIME_UNIT,
   parameter [39:0] SAVE_CYC = `SAVE_PERIOD_CYC
) (
   // Clock and reset.
   input wire core_clk,
   input wire srst,
   // Register port.
   input wire [7:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   // Contact input pins.
   input wire [4:0] terminal_in,
   input wire forward_start_input,
   input wire reverse_start_input,
   // Operator panel keys (pins).
   input wire panel_run_key,
   input wire panel_fwd_key,
   input wire panel_rev_key,
   input wire panel_stop_key,
   // Mode qualifiers from drive logic.
   input wire panel_jog_mode,
   input wire panel_op_sel,
   input wire network_op,
   input wire pid_active,
   // Frequency sources from drive logic, 0.01 Hz units.
   input wire [15:0] panel_freq,
   input wire [15:0] ain4_freq,
   input wire [15:0] ain2_freq,
   input wire ain4_sel,
   input wire [15:0] multispeed_freq,
   // Nonvolatile store.
   input wire nv_load_valid,
   input wire [15:0] nv_load_data,
   output reg nv_wr,
   output reg [15:0] nv_wdata,
   // Frequency reference and run state.
   output reg [16:0] freq_ref,
   output reg [16:0] target_freq,
   output reg run_fwd,
   output reg run_rev,
   output reg jog_active,
   output reg remote_active
);

   // Configuration registers.
   reg [15:0] jog_freq_q;
   reg [15:0] jog_ramp_q;
   reg [15:0] ref_freq_q;
   reg [15:0] base_freq_q;
   reg [1:0] pattern_q;
   reg [2:0] op_mode_q;
   reg [1:0] remote_sel_q;
   reg [19:0] term_assign_q;
   reg [15:0] max_freq_q;
   reg [15:0] accel_q;
   reg [15:0] decel_q;
   reg [15:0] second_accel_q;
   reg [15:0] second_decel_q;
   reg [15:0] start_freq_q;
   // Pin synchroniser stages.
   reg [10:0] sync1_q;
   reg [10:0] sync_q;
   // Block state.
   reg [15:0] offset_q;
   reg [15:0] stored_q;
   reg started_q;
   reg run_latch_q;
   reg run_latch_rev_q;
   reg [47:0] ramp_acc_q;
   reg [47:0] offs_acc_q;
   reg [39:0] save_cnt_q;

   // Clamps a written value to an upper limit.
   function [15:0] clamp16;
      input [31:0] v;
      input [15:0] lim;
      begin
         if (v[31:16] != 16'h0000 || v[15:0] > lim) begin
            clamp16 = lim;
         end else begin
            clamp16 = v[15:0];
         end
      end
   endfunction

   // True when any terminal carries the given function code and is active.
   function func_on;
      input [3:0] code;
      input [19:0] codes;
      input [4:0] pins;
      integer i;
      begin
         func_on = 1'b0;
         for (i = 0; i < 5; i = i + 1) begin
            if (codes[4*i +: 4] == code && pins[i]) begin
               func_on = 1'b1;
            end
         end
      end
   endfunction

   // Two-stage synchroniser for every pin input.
   always @(posedge core_clk) begin
      if (srst) begin
         sync1_q <= 11'h000;
         sync_q <= 11'h000;
      end else begin
         sync1_q <= {panel_stop_key, panel_rev_key, panel_fwd_key, panel_run_key,
                     reverse_start_input, forward_start_input, terminal_in};
         sync_q <= sync1_q;
      end
   end

   wire [4:0] term_s = sync_q[4:0];
   wire fwd_s = sync_q[5];
   wire rev_s = sync_q[6];
   wire key_run = sync_q[7];
   wire key_fwd = sync_q[8];
   wire key_rev = sync_q[9];
   wire key_stop = sync_q[10];

   // Terminal function routing.
   wire jog_pin = func_on(`FUNC_JOG, term_assign_q, term_s);
   wire high_in = func_on(`FUNC_HIGH, term_assign_q, term_s);
   wire mid_in = func_on(`FUNC_MID, term_assign_q, term_s);
   wire low_in = func_on(`FUNC_LOW, term_assign_q, term_s);
   wire second_in = func_on(`FUNC_SECOND, term_assign_q, term_s);

   // Mode decode.
   wire pu_mode = (op_mode_q == `MODE_PANEL) || (op_mode_q == `MODE_SWITCH && panel_op_sel);
   wire mode3 = (op_mode_q == `MODE_COMBINED_FREQ);
   wire mode4 = (op_mode_q == `MODE_COMBINED_START);
   wire panel_start = pu_mode || mode4;

   // Jog sources; none of them is honoured in mode 3.
   wire contact_jog = jog_pin && !panel_start && !mode3;
   wire held_jog = panel_jog_mode && pu_mode && (key_run || key_fwd || key_rev);
   wire latched_jog = panel_jog_mode && mode4 && run_latch_q;
   wire jog_on = contact_jog || (!mode3 && (held_jog || latched_jog));

   // Run direction; both contact starts together means stop.
   wire contact_fwd = fwd_s && !rev_s;
   wire contact_rev = rev_s && !fwd_s;
   reg dir_fwd;
   reg dir_rev;
   always @* begin
      if (held_jog) begin
         dir_fwd = (key_run || key_fwd) && !key_rev;
         dir_rev = key_rev && !key_run && !key_fwd;
      end else if (panel_start) begin
         dir_fwd = run_latch_q && !run_latch_rev_q;
         dir_rev = run_latch_q && run_latch_rev_q;
      end else begin
         dir_fwd = contact_fwd;
         dir_rev = contact_rev;
      end
   end
   wire running = dir_fwd || dir_rev;
   wire contact_started = fwd_s || rev_s;

   // Remote function decode.
   wire remote_sel_on = (remote_sel_q != `REMOTE_MULTI);
   wire remote_on = remote_sel_on && !jog_on && !pid_active;
   wire up_cmd = remote_on && high_in && !mid_in;
   wire down_cmd = remote_on && mid_in && !high_in;
   wire clear_cmd = remote_on && low_in;
   wire adj_allowed = (remote_sel_q != `REMOTE_CLEAR_AT_STOP) || contact_started;
   wire ms_on = !remote_sel_on && !pu_mode && (high_in || mid_in || low_in);

   // Base command by mode, network using the external command.
   reg [15:0] base_cmd;
   always @* begin
      if (network_op) begin
         base_cmd = ain4_sel ? ain4_freq : ain2_freq;
      end else if (mode3) begin
         base_cmd = ain4_sel ? ain4_freq : panel_freq;
      end else if (pu_mode) begin
         base_cmd = panel_freq;
      end else begin
         base_cmd = ain4_sel ? ain4_freq : ain2_freq;
      end
   end

   // Target with jog above multi-speed above analog commands.
   wire [16:0] offs_eff = remote_on ? {1'b0, offset_q} : 17'h00000;
   wire [16:0] cap_sum = {1'b0, base_cmd} + {1'b0, max_freq_q};
   wire [16:0] raw_sum = {1'b0, base_cmd} + offs_eff;
   wire [16:0] set_sum = (raw_sum > cap_sum) ? cap_sum : raw_sum;
   reg [16:0] target_d;
   always @* begin
      if (jog_on) begin
         target_d = running ? {1'b0, jog_freq_q} : 17'h00000;
      end else if (!running) begin
         target_d = 17'h00000;
      end else if (ms_on && !network_op) begin
         target_d = {1'b0, multispeed_freq};
      end else begin
         target_d = set_sum;
      end
   end

   // Ramp time selection for acceleration and deceleration.
   wire [15:0] sec_dec = (second_decel_q == `TIME_NOT_SET) ? second_accel_q : second_decel_q;
   wire rem_adj = up_cmd || down_cmd;
   reg [15:0] acc_time;
   reg [15:0] dec_time;
   always @* begin
      if (jog_on) begin
         acc_time = jog_ramp_q;
         dec_time = jog_ramp_q;
      end else if (second_in) begin
         acc_time = second_accel_q;
         dec_time = sec_dec;
      end else if (rem_adj) begin
         acc_time = (accel_q > second_accel_q) ? accel_q : second_accel_q;
         dec_time = (decel_q > sec_dec) ? decel_q : sec_dec;
      end else begin
         acc_time = accel_q;
         dec_time = decel_q;
      end
   end

   // Ramp span is base frequency under S-curve A in jog, else the reference frequency.
   wire [15:0] span = (jog_on && pattern_q == `PATTERN_S_A) ? base_freq_q : ref_freq_q;
   wire going_up = target_d > freq_ref;
   wire [15:0] main_time = going_up ? acc_time : dec_time;
   wire [47:0] main_thr = main_time * CYC_PER_UNIT;
   wire [47:0] main_sum = ramp_acc_q + {32'h00000000, span};
   wire [15:0] offs_time = up_cmd ? acc_time : dec_time;
   wire [47:0] offs_thr = offs_time * CYC_PER_UNIT;
   wire [47:0] offs_sum = offs_acc_q + {32'h00000000, ref_freq_q};

   // Ramp generator: one 0.01 Hz step each time the span accumulator passes the time.
   always @(posedge core_clk) begin
      if (srst) begin
         freq_ref <= 17'h00000;
         ramp_acc_q <= 48'h000000000000;
      end else if (target_d == freq_ref) begin
         ramp_acc_q <= 48'h000000000000;
      end else if (main_time == 16'h0000) begin
         freq_ref <= target_d;
         ramp_acc_q <= 48'h000000000000;
      end else if (main_sum >= main_thr) begin
         freq_ref <= going_up ? freq_ref + 17'h00001 : freq_ref - 17'h00001;
         ramp_acc_q <= main_sum - main_thr;
      end else begin
         ramp_acc_q <= main_sum;
      end
   end

   // Panel run latch for modes that start from the panel.
   always @(posedge core_clk) begin
      if (srst) begin
         run_latch_q <= 1'b0;
         run_latch_rev_q <= 1'b0;
      end else if (key_stop || !panel_start || (panel_jog_mode && pu_mode)) begin
         run_latch_q <= 1'b0;
      end else if (key_run || key_fwd) begin
         run_latch_q <= 1'b1;
         run_latch_rev_q <= 1'b0;
      end else if (key_rev) begin
         run_latch_q <= 1'b1;
         run_latch_rev_q <= 1'b1;
      end
   end

   // Remote offset, its storage and the periodic compare-and-save.
   wire start_fall = started_q && !contact_started;
   wire save_idle = remote_on && !high_in && !mid_in && (remote_sel_q == `REMOTE_STORED);
   wire save_tick = save_idle && (save_cnt_q == SAVE_CYC - 40'h0000000001);
   always @(posedge core_clk) begin
      if (srst) begin
         offset_q <= 16'h0000;
         stored_q <= 16'h0000;
         started_q <= 1'b0;
         offs_acc_q <= 48'h000000000000;
         save_cnt_q <= 40'h0000000000;
         nv_wr <= 1'b0;
         nv_wdata <= 16'h0000;
      end else begin
         started_q <= contact_started;
         nv_wr <= 1'b0;
         if (nv_load_valid) begin
            stored_q <= nv_load_data;
            if (remote_sel_q == `REMOTE_STORED) begin
               offset_q <= clamp16({16'h0000, nv_load_data}, max_freq_q);
            end
         end else if (clear_cmd) begin
            offset_q <= 16'h0000;
            offs_acc_q <= 48'h000000000000;
         end else if (start_fall && remote_sel_q == `REMOTE_CLEAR_AT_STOP) begin
            offset_q <= 16'h0000;
         end else if (rem_adj && adj_allowed) begin
            if (offs_time == 16'h0000 || offs_sum >= offs_thr) begin
               offs_acc_q <= (offs_time == 16'h0000) ? 48'h000000000000 : offs_sum - offs_thr;
               if (up_cmd && offset_q < max_freq_q) begin
                  offset_q <= offset_q + 16'h0001;
               end else if (down_cmd && offset_q != 16'h0000) begin
                  offset_q <= offset_q - 16'h0001;
               end
            end else begin
               offs_acc_q <= offs_sum;
            end
         end else if (offset_q > max_freq_q) begin
            offset_q <= max_freq_q;
         end
         // Saving ignores the clear input and follows start release or the minute tick.
         if (remote_sel_q == `REMOTE_STORED && remote_on &&
             (start_fall || (save_tick && offset_q != stored_q))) begin
            nv_wr <= 1'b1;
            nv_wdata <= offset_q;
            stored_q <= offset_q;
         end
         if (!save_idle || save_tick) begin
            save_cnt_q <= 40'h0000000000;
         end else begin
            save_cnt_q <= save_cnt_q + 40'h0000000001;
         end
      end
   end

   // Registered run and status outputs.
   always @(posedge core_clk) begin
      if (srst) begin
         target_freq <= 17'h00000;
         run_fwd <= 1'b0;
         run_rev <= 1'b0;
         jog_active <= 1'b0;
         remote_active <= 1'b0;
      end else begin
         target_freq <= target_d;
         run_fwd <= dir_fwd;
         run_rev <= dir_rev;
         jog_active <= jog_on;
         remote_active <= remote_on;
      end
   end

   // Register writes with range clamping.
   always @(posedge core_clk) begin
      if (srst) begin
         jog_freq_q <= `RST_JOG_FREQ;
         jog_ramp_q <= `RST_JOG_RAMP;
         ref_freq_q <= `RST_REF_FREQ;
         base_freq_q <= `RST_BASE_FREQ;
         pattern_q <= 2'h0;
         op_mode_q <= 3'h0;
         remote_sel_q <= 2'h0;
         term_assign_q <= `RST_TERM_ASSIGN;
         max_freq_q <= `RST_MAX_FREQ;
         accel_q <= `RST_ACCEL_TIME;
         decel_q <= `RST_ACCEL_TIME;
         second_accel_q <= `RST_ACCEL_TIME;
         second_decel_q <= `TIME_NOT_SET;
         start_freq_q <= `RST_START_FREQ;
      end else if (reg_wr) begin
         if (reg_addr == `ADDR_JOG_FREQ) begin
            jog_freq_q <= clamp16(reg_wdata, `MAX_SET_FREQ);
         end else if (reg_addr == `ADDR_JOG_RAMP) begin
            jog_ramp_q <= clamp16(reg_wdata, `MAX_SET_TIME);
         end else if (reg_addr == `ADDR_REF_FREQ) begin
            ref_freq_q <= (reg_wdata[15:0] == 16'h0000) ? 16'h0001 :
                          clamp16(reg_wdata, `MAX_SET_FREQ);
         end else if (reg_addr == `ADDR_BASE_FREQ) begin
            base_freq_q <= clamp16(reg_wdata, `MAX_SET_FREQ);
         end else if (reg_addr == `ADDR_RAMP_PATTERN) begin
            pattern_q <= reg_wdata[1:0];
         end else if (reg_addr == `ADDR_OP_MODE) begin
            op_mode_q <= (reg_wdata[2:0] > 3'h4) ? 3'h4 : reg_wdata[2:0];
         end else if (reg_addr == `ADDR_REMOTE_SEL) begin
            remote_sel_q <= reg_wdata[1:0];
         end else if (reg_addr == `ADDR_TERM_ASSIGN) begin
            term_assign_q <= reg_wdata[19:0];
         end else if (reg_addr == `ADDR_MAX_FREQ) begin
            max_freq_q <= clamp16(reg_wdata, `MAX_SET_FREQ);
         end else if (reg_addr == `ADDR_ACCEL_TIME) begin
            accel_q <= clamp16(reg_wdata, `MAX_SET_TIME);
         end else if (reg_addr == `ADDR_DECEL_TIME) begin
            decel_q <= clamp16(reg_wdata, `MAX_SET_TIME);
         end else if (reg_addr == `ADDR_SECOND_ACCEL) begin
            second_accel_q <= clamp16(reg_wdata, `MAX_SET_TIME);
         end else if (reg_addr == `ADDR_SECOND_DECEL) begin
            second_decel_q <= (reg_wdata[15:0] == `TIME_NOT_SET) ? `TIME_NOT_SET :
                              clamp16(reg_wdata, `MAX_SET_TIME);
         end else if (reg_addr == `ADDR_START_FREQ) begin
            start_freq_q <= clamp16(reg_wdata, `MAX_SET_FREQ);
         end
      end
   end

   // Read data, valid in the cycle after the read strobe; unmapped reads give zero.
   always @(posedge core_clk) begin
      if (srst) begin
         reg_rdata <= 32'h00000000;
      end else if (!reg_rd) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_addr == `ADDR_JOG_FREQ) begin
         reg_rdata <= {16'h0000, jog_freq_q};
      end else if (reg_addr == `ADDR_JOG_RAMP) begin
         reg_rdata <= {16'h0000, jog_ramp_q};
      end else if (reg_addr == `ADDR_REF_FREQ) begin
         reg_rdata <= {16'h0000, ref_freq_q};
      end else if (reg_addr == `ADDR_BASE_FREQ) begin
         reg_rdata <= {16'h0000, base_freq_q};
      end else if (reg_addr == `ADDR_RAMP_PATTERN) begin
         reg_rdata <= {30'h00000000, pattern_q};
      end else if (reg_addr == `ADDR_OP_MODE) begin
         reg_rdata <= {29'h00000000, op_mode_q};
      end else if (reg_addr == `ADDR_REMOTE_SEL) begin
         reg_rdata <= {30'h00000000, remote_sel_q};
      end else if (reg_addr == `ADDR_TERM_ASSIGN) begin
         reg_rdata <= {12'h000, term_assign_q};
      end else if (reg_addr == `ADDR_MAX_FREQ) begin
         reg_rdata <= {16'h0000, max_freq_q};
      end else if (reg_addr == `ADDR_ACCEL_TIME) begin
         reg_rdata <= {16'h0000, accel_q};
      end else if (reg_addr == `ADDR_DECEL_TIME) begin
         reg_rdata <= {16'h0000, decel_q};
      end else if (reg_addr == `ADDR_SECOND_ACCEL) begin
         reg_rdata <= {16'h0000, second_accel_q};
      end else if (reg_addr == `ADDR_SECOND_DECEL) begin
         reg_rdata <= {16'h0000, second_decel_q};
      end else if (reg_addr == `ADDR_START_FREQ) begin
         reg_rdata <= {16'h0000, start_freq_q};
      end else if (reg_addr == `ADDR_STATUS) begin
         reg_rdata <= {26'h0000000, second_in, ms_on, remote_on, jog_on, dir_rev, dir_fwd};
      end else if (reg_addr == `ADDR_OUT_FREQ) begin
         reg_rdata <= {15'h0000, freq_ref};
      end else if (reg_addr == `ADDR_REMOTE_OFFSET) begin
         reg_rdata <= {16'h0000, offset_q};
      end else if (reg_addr == `ADDR_STORED_FREQ) begin
         reg_rdata <= {16'h0000, stored_q};
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end

endmodule

// [jog_remote_checker.sv]
// Port checker for the jog and remote speed logic.
`timescale 1ns/1ps
`include "jog_remote_regs.vh"
module jog_remote_checker (
   // Clock, reset and register port.
   input wire core_clk,
   input wire srst,
   input wire [7:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [31:0] reg_rdata,
   // Qualifier and outputs.
   input wire pid_active,
   input wire nv_wr,
   input wire [16:0] target_freq,
   input wire run_fwd,
   input wire run_rev,
   input wire jog_active,
   input wire remote_active
);
   reg [15:0] jf_q;
   reg [2:0] op_q;
   reg [1:0] sel_q;
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   // Shadows of settings written in range by software.
   always @(posedge core_clk) begin
      if (srst) begin
         jf_q <= `RST_JOG_FREQ;
         op_q <= 3'h0;
         sel_q <= 2'h0;
      end else if (reg_wr) begin
         if (reg_addr == `ADDR_JOG_FREQ) jf_q <= reg_wdata[15:0];
         if (reg_addr == `ADDR_OP_MODE) op_q <= reg_wdata[2:0];
         if (reg_addr == `ADDR_REMOTE_SEL) sel_q <= reg_wdata[1:0];
      end
   end
   sequence pid_held;
      pid_active [*4];
   endsequence
   sequence rd_jog;
      reg_rd && reg_addr == `ADDR_JOG_FREQ;
   endsequence
   rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data not zero outside read answer");
   jog_read_a: assert property (rd_jog |=> reg_rdata == {16'h0, jf_q})
      else $error("jog frequency read wrong");
   jog_target_a: assert property (jog_active |-> target_freq == {1'b0, jf_q})
      else $error("jog target not jog frequency");
   mode3_jog_a: assert property (op_q == 3'h3 && $past(op_q, 3) == 3'h3 |-> !jog_active)
      else $error("jog active in mode 3");
   jog_remote_a: assert property (jog_active |-> !remote_active)
      else $error("remote active during jog");
   pid_remote_a: assert property (pid_held |-> !remote_active)
      else $error("remote active during pid");
   nv_pulse_a: assert property (nv_wr |=> !nv_wr)
      else $error("store pulse longer than one cycle");
   nv_sel_a: assert property (nv_wr |-> sel_q == `REMOTE_STORED)
      else $error("store without storing selection");
   dir_excl_a: assert property (run_fwd |-> !run_rev)
      else $error("both directions running");
   sel0_off_a: assert property (sel_q == 2'h0 && $past(sel_q, 3) == 2'h0 |-> !remote_active)
      else $error("remote active with selection 0");
endmodule
bind jog_remote_speed jog_remote_checker chk (.*);

// [contact_panel_model.sv]
// Contact wiring and operator panel in front of the drive.
`timescale 1ns/1ps
module contact_panel_model (
   // Clock and requested contact states.
   input wire core_clk,
   input wire [10:0] want,
   // Contacts and panel keys.
   output reg [4:0] terminal_in = 5'h00,
   output reg forward_start_input = 1'b0,
   output reg reverse_start_input = 1'b0,
   output reg panel_run_key = 1'b0,
   output reg panel_fwd_key = 1'b0,
   output reg panel_rev_key = 1'b0,
   output reg panel_stop_key = 1'b0
);
   // Contacts settle one cycle after a request; jog select sits on terminal 4.
   always @(posedge core_clk) begin
      {panel_stop_key, panel_rev_key, panel_fwd_key, panel_run_key, reverse_start_input,
         forward_start_input, terminal_in} <= want;
   end
endmodule

// [tb.sv]
// Self-checking bench for the jog and remote speed logic.
`timescale 1ns/1ps
`include "jog_remote_regs.vh"
module tb;
   localparam [31:0] ALL = 32'hFFFFFFFF;
   reg core_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_seen = 1'b0;
   reg [7:0] reg_addr = 8'h00;
   reg [31:0] reg_wdata = 32'h0, jf;
   reg pid_active = 1'b0, panel_jog_mode = 1'b0, nv_load_valid = 1'b0;
   reg panel_op_sel = 1'b0, network_op = 1'b0, ain4_sel = 1'b0;
   reg [15:0] nv_load_data = 16'h0, panel_freq = 16'h0, ain4_freq = 16'h0;
   reg [15:0] ain2_freq = 16'h0, multispeed_freq = 16'h0;
   reg [10:0] want = 11'h000;
   wire [31:0] reg_rdata;
   wire [4:0] terminal_in;
   wire forward_start_input, reverse_start_input, panel_run_key, panel_fwd_key;
   wire panel_rev_key, panel_stop_key, nv_wr, run_fwd, run_rev, jog_active, remote_active;
   wire [15:0] nv_wdata;
   wire [16:0] freq_ref, target_freq;
   integer fails = 0, checks_done = 0, cyc = 0, seed = 60;
   reg [63:0] rq[$];
   reg [63:0] note;
   reg [15:0] nq[$];
   jog_remote_speed #(.CYC_PER_UNIT(32'd20), .SAVE_CYC(40'd1000)) uut (.*);
   contact_panel_model m (.*);
   // Free-running 200 MHz clock.
   always #2.5 core_clk = ~core_clk;
   task cmp(input [47:0] n, input [31:0] e, input [31:0] s);
      begin
         checks_done = checks_done + 1;
         if (s !== e) begin
            fails = fails + 1;
            $display("mismatch %0s expected %h seen %h", n, e, s);
         end
      end
   endtask
   task final_report;
      begin
         fails = fails + rq.size() + nq.size();
         $display("checks_done %0d fails %0d", checks_done, fails);
         if (fails == 0 && checks_done > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      begin
         reg_wr <= 1'b1;
         reg_addr <= a;
         reg_wdata <= d;
         @(posedge core_clk);
         reg_wr <= 1'b0;
         @(posedge core_clk);
      end
   endtask
   task rd(input [7:0] a, input [31:0] k, input [31:0] e);
      begin
         rq.push_back({k, e & k});
         reg_rd <= 1'b1;
         reg_addr <= a;
         @(posedge core_clk);
         reg_rd <= 1'b0;
         @(posedge core_clk);
      end
   endtask
   // Takes the oldest note whenever read data or a store pulse appears.
   always @(posedge core_clk) begin
      rd_seen <= reg_rd;
      cyc = cyc + 1;
      if (rd_seen) begin
         note = rq.pop_front();
         cmp("rdata", note[31:0], reg_rdata & note[63:32]);
      end
      if (nv_wr) cmp("nvdata", nq.size() ? {16'h0, nq.pop_front()} : 32'h10000, nv_wdata);
      if (cyc > 20000) begin
         fails = fails + 1;
         final_report;
      end
   end
   // Main sequence: defaults, jog, mode 3, panel jog, remote and storage.
   initial begin
      repeat (8) @(posedge core_clk);
      srst <= 1'b0;
      {panel_freq, ain4_freq, ain2_freq, multispeed_freq} <= {$random(seed), $random(seed)};
      @(posedge core_clk);
      rd(`ADDR_JOG_FREQ, ALL, `RST_JOG_FREQ);
      rd(`ADDR_JOG_RAMP, ALL, `RST_JOG_RAMP);
      rd(`ADDR_REF_FREQ, ALL, `RST_REF_FREQ);
      rd(8'h50, ALL, 32'h0);
      jf = `RST_START_FREQ + $unsigned($random(seed)) % 39951;
      wr(`ADDR_JOG_FREQ, jf);
      rd(`ADDR_JOG_FREQ, ALL, jf);
      wr(`ADDR_JOG_RAMP, 32'h0);
      wr(`ADDR_OP_MODE, 32'h2);
      wr(`ADDR_REMOTE_SEL, 32'h1);
      want <= 11'h030;
      repeat (6) @(posedge core_clk);
      rd(`ADDR_STATUS, 32'h3F, 32'h05);
      rd(`ADDR_OUT_FREQ, ALL, jf);
      wr(`ADDR_OP_MODE, 32'h3);
      repeat (5) @(posedge core_clk);
      rd(`ADDR_STATUS, 32'h4, 32'h0);
      nq.push_back(16'h0);
      want <= 11'h000;
      wr(`ADDR_OP_MODE, 32'h1);
      panel_jog_mode <= 1'b1;
      want <= 11'h100;
      repeat (6) @(posedge core_clk);
      rd(`ADDR_STATUS, 32'h5, 32'h5);
      want <= 11'h000;
      repeat (6) @(posedge core_clk);
      rd(`ADDR_STATUS, 32'h1, 32'h0);
      wr(`ADDR_OP_MODE, 32'h4);
      want <= 11'h080;
      repeat (6) @(posedge core_clk);
      want <= 11'h000;
      repeat (6) @(posedge core_clk);
      rd(`ADDR_STATUS, 32'h5, 32'h5);
      want <= 11'h400;
      repeat (6) @(posedge core_clk);
      rd(`ADDR_STATUS, 32'h5, 32'h0);
      panel_jog_mode <= 1'b0;
      wr(`ADDR_OP_MODE, 32'h2);
      nv_load_data <= 16'h7;
      nv_load_valid <= 1'b1;
      @(posedge core_clk);
      nv_load_valid <= 1'b0;
      rd(`ADDR_REMOTE_OFFSET, ALL, 32'h7);
      rd(`ADDR_STORED_FREQ, ALL, 32'h7);
      wr(`ADDR_MAX_FREQ, 32'h3);
      want <= 11'h004;
      repeat (300) @(posedge core_clk);
      rd(`ADDR_REMOTE_OFFSET, ALL, 32'h3);
      want <= 11'h020;
      pid_active <= 1'b1;
      repeat (6) @(posedge core_clk);
      rd(`ADDR_STATUS, 32'h8, 32'h0);
      pid_active <= 1'b0;
      nq.push_back(16'h3);
      repeat (6) @(posedge core_clk);
      want <= 11'h001;
      repeat (10) @(posedge core_clk);
      rd(`ADDR_REMOTE_OFFSET, ALL, 32'h0);
      nq.push_back(16'h0);
      want <= 11'h000;
      repeat (2100) @(posedge core_clk);
      final_report;
   end
endmodule
